// ===== core/bae_pkg.sv
// Package for the beam area block evaluation: types, map and codes
package bae_pkg;

	// Geometry of the curtain and the area set
	localparam int AREA_COUNT = 32;
	localparam int BEAM_MAX   = 1774;

	// Parameter indices; byte address is four times the index
	localparam logic [9:0] IDX_SELECTOR   = 10'h063;
	localparam logic [9:0] IDX_AREA_FIRST = 10'h064;
	localparam logic [9:0] IDX_AREA_LAST  = 10'h083;
	localparam logic [9:0] IDX_STATUS_LO  = 10'h09e;
	localparam logic [9:0] IDX_STATUS_HI  = 10'h09f;

	// Detail window: four words of the selected area record
	localparam logic [7:0] DETAIL_BASE_HI = 8'h40;

	// Field positions inside the 112-bit record
	localparam int POS_ENABLE   = 104;
	localparam int POS_POLARITY = 96;
	localparam int POS_START    = 80;
	localparam int POS_END      = 64;
	localparam int POS_ON       = 48;
	localparam int POS_OFF      = 32;
	localparam int POS_MIDDLE   = 16;
	localparam int POS_WIDTH    = 0;

	// Reserved beam codes that point at dynamic beams
	localparam logic [15:0] CODE_FIRST_BLOCKED = 16'hfffe;
	localparam logic [15:0] CODE_FIRST_CLEAR   = 16'hfffd;
	localparam logic [15:0] CODE_LAST_BLOCKED  = 16'hfffc;
	localparam logic [15:0] CODE_LAST_CLEAR    = 16'hfffb;
	localparam logic [15:0] CODE_TARGET_MIN    = 16'hfffa;

	// Reset values
	localparam logic [7:0]  SELECTOR_RESET = 8'h00;
	localparam logic [15:0] BEAM_RESET     = 16'h0001;

	// Area configuration record, msb first as laid out in the record
	typedef struct packed {
		logic [7:0]  enable;
		logic [7:0]  polarity;
		logic [15:0] start_beam;
		logic [15:0] end_beam;
		logic [15:0] on_count;
		logic [15:0] off_count;
		logic [15:0] middle;
		logic [15:0] width;
	} bae_area_cfg_type;

	localparam bae_area_cfg_type AREA_CFG_RESET = '{
		enable: 8'h00, polarity: 8'h00,
		start_beam: BEAM_RESET, end_beam: BEAM_RESET,
		on_count: 16'h0000, off_count: 16'h0000,
		middle: 16'h0000, width: 16'h0000};

	// Dynamic beam numbers from the measurement logic
	typedef struct packed {
		logic [15:0] first_blocked_beam;
		logic [15:0] first_clear_beam;
		logic [15:0] last_blocked_beam;
		logic [15:0] last_clear_beam;
		logic [15:0] target_minimum;
	} bae_refs_type;

	// Turns a start or end field into a beam number
	function automatic logic [15:0] bae_resolve(
		input logic [15:0]  code,
		input bae_refs_type refs);
		case (code)
			CODE_FIRST_BLOCKED: bae_resolve = refs.first_blocked_beam;
			CODE_FIRST_CLEAR:   bae_resolve = refs.first_clear_beam;
			CODE_LAST_BLOCKED:  bae_resolve = refs.last_blocked_beam;
			CODE_LAST_CLEAR:    bae_resolve = refs.last_clear_beam;
			CODE_TARGET_MIN:    bae_resolve = refs.target_minimum;
			default:            bae_resolve = code;
		endcase
	endfunction

endpackage

// ===== core/bae_area_eval.sv
// One area: counts active beams of a scan and keeps the hysteretic result
`timescale 1ns/10ps
module bae_area_eval
	import bae_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire bae_area_cfg_type cfg,
	input  wire bae_refs_type     refs,
	input  wire logic             beam_valid,
	input  wire logic [15:0]      beam_num,
	input  wire logic             beam_blocked,
	input  wire logic             scan_end,
	output logic                  result
);

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic        result_reg;
	logic        result_next;

	// Resolved boundaries; either order of start and end is accepted
	wire  [15:0] start_num = bae_resolve(cfg.start_beam, refs);
	wire  [15:0] end_num   = bae_resolve(cfg.end_beam, refs);
	wire  [15:0] low_num   = (start_num <= end_num) ? start_num : end_num;
	wire  [15:0] high_num  = (start_num <= end_num) ? end_num : start_num;
	wire         in_area   = (beam_num >= low_num) && (beam_num <= high_num);

	// Light switching counts free beams, dark switching blocked ones
	wire         dark      = (cfg.polarity != 8'h00);
	wire         active    = dark ? beam_blocked : !beam_blocked;
	wire         hit       = beam_valid && in_area && active;
	wire  [15:0] total     = count_reg + {15'h0000, hit};
	wire         enabled   = (cfg.enable != 8'h00);

	// Counter restarts after each scan; last beam may share scan_end
	assign count_next = scan_end ? 16'h0000 : total;

	// Result: ON wins when thresholds overlap, gap holds the old value
	always_comb begin
		result_next = result_reg;
		if (scan_end) begin
			if (!enabled) begin
				result_next = 1'b0;
			end else if (total >= cfg.on_count) begin
				result_next = 1'b1;
			end else if (total <= cfg.off_count) begin
				result_next = 1'b0;
			end else begin
				result_next = result_reg;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg  <= 16'h0000;
			result_reg <= 1'b0;
		end else begin
			count_reg  <= count_next;
			result_reg <= result_next;
		end
	end

	assign result = result_reg;

endmodule

// ===== core/bae_top.sv
// Beam area block evaluation: APB register file and thirty-two areas
//
// Function
// - An 8-bit selector picks the area whose whole record the detail window shows, low five bits n meaning area n+1.
// - Each of the thirty-two areas owns a 112-bit read-write record at parameter indices 100 to 131; the index reaches word 0 only, the window all four.
// - The record holds an 8-bit enable at bit 104, an 8-bit polarity at bit 96 and beam fields from bit 80.
// - Polarity zero makes free beams active, polarity one makes interrupted beams active.
// - Start and end codes 65534 to 65530 select first blocked, first clear, last blocked, last clear and target minimum beams.
// - An area result goes to one when its active-beam count reaches the ON threshold.
// - An area result goes to zero when its active-beam count is at or below the OFF threshold at bit 32 and below the ON threshold.
// - Each record keeps a 16-bit middle at bit 16 and a 16-bit width at bit 0, both zero after reset.
// - Results of areas one to sixteen form the low status word, seventeen to thirty-two the high one.
//
// Middle and width are stored only; dynamic beam numbers come in on
// BEAM_REFS from the measurement logic and must hold still during a scan.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module bae_top
	import bae_pkg::*;
(
	input  wire logic          SYS_CLK,
	input  wire logic          RESET,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [11:0]   PADDR,
	input  wire logic [31:0]   PWDATA,
	input  wire logic [3:0]    PSTRB,
	output logic      [31:0]   PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	input  wire logic          BEAM_VALID,
	input  wire logic [15:0]   BEAM_NUM,
	input  wire logic          BEAM_BLOCKED,
	input  wire logic          SCAN_END,
	input  wire bae_refs_type  BEAM_REFS,
	output logic      [15:0]   AREA_STATUS_LO,
	output logic      [15:0]   AREA_STATUS_HI
);

	// Configuration state; results are the evaluator outputs, one bit
	// per area, and status_reg freezes them one edge later so the pins
	// never show a result that is still settling
	bae_area_cfg_type cfg_reg [AREA_COUNT];
	logic [7:0]       selector_reg;
	logic [AREA_COUNT-1:0] results;
	logic [31:0]      status_reg;

	// Bus answer registers
	logic [31:0]      prdata_reg;
	logic [31:0]      prdata_next;
	logic             pready_reg;
	logic             pslverr_reg;
	logic             pslverr_next;

	// Reads one 32-bit word of a record; top word has 16 bits only
	function automatic logic [31:0] rec_word(
		input bae_area_cfg_type rec,
		input logic [1:0]       sel);
		logic [111:0] flat;
		flat = rec;
		case (sel)
			2'h0:    rec_word = flat[31:0];
			2'h1:    rec_word = flat[63:32];
			2'h2:    rec_word = flat[95:64];
			default: rec_word = {16'h0000, flat[111:96]};
		endcase
	endfunction

	// Applies byte strobes to one word
	function automatic logic [31:0] strobe_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_w[8*b +: 8];
			end
		end
		strobe_merge = res;
	endfunction

	// Writes one word into a record, returning the new record
	function automatic bae_area_cfg_type rec_put(
		input bae_area_cfg_type rec,
		input logic [1:0]       sel,
		input logic [31:0]      w);
		logic [111:0] flat;
		flat = rec;
		case (sel)
			2'h0:    flat[31:0]   = w;
			2'h1:    flat[63:32]  = w;
			2'h2:    flat[95:64]  = w;
			default: flat[111:96] = w[15:0];
		endcase
		rec_put = flat;
	endfunction

	// Address decode on the word index; bits 1:0 are ignored, so an
	// unaligned address reaches the word that holds it
	wire  [9:0] word_idx   = PADDR[11:2];
	wire        hit_sel    = (word_idx == IDX_SELECTOR);
	wire        hit_area   = (word_idx >= IDX_AREA_FIRST) &&
	                         (word_idx <= IDX_AREA_LAST);
	wire  [9:0] area_off   = word_idx - IDX_AREA_FIRST;
	wire  [4:0] direct_idx = area_off[4:0];
	wire        hit_detail = (PADDR[11:4] == DETAIL_BASE_HI);
	wire  [1:0] detail_wd  = PADDR[3:2];
	wire  [4:0] detail_idx = selector_reg[4:0];
	wire        hit_lo     = (word_idx == IDX_STATUS_LO);
	wire        hit_hi     = (word_idx == IDX_STATUS_HI);
	wire        mapped     = hit_sel || hit_area || hit_detail ||
	                         hit_lo || hit_hi;

	// Status words are read-only; a write there is an error
	wire        status_wr  = PWRITE && (hit_lo || hit_hi);
	wire        setup      = PSEL && !PENABLE;
	wire        wr_take    = PSEL && PENABLE && pready_reg && PWRITE &&
	                         !pslverr_reg;

	// Read data chosen in the setup cycle
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (hit_sel) begin
			prdata_next = {24'h000000, selector_reg};
		end else if (hit_area) begin
			prdata_next = rec_word(cfg_reg[direct_idx], 2'h0);
		end else if (hit_detail) begin
			prdata_next = rec_word(cfg_reg[detail_idx], detail_wd);
		end else if (hit_lo) begin
			prdata_next = {16'h0000, status_reg[15:0]};
		end else if (hit_hi) begin
			prdata_next = {16'h0000, status_reg[31:16]};
		end
	end

	// Unmapped or status-word writes answer with an error, never a hang
	assign pslverr_next = !mapped || status_wr;

	// Slave answers in the first access cycle, no wait states
	// PREADY is a one-cycle pulse, so a master never sees a wait state
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && pslverr_next;
			prdata_reg  <= (setup && !PWRITE) ? prdata_next : 32'h0000_0000;
		end
	end

	// Lanes merged on a zero-padded word; only the low byte is kept
	wire [31:0] sel_merged = strobe_merge({24'h000000, selector_reg},
	                                      PWDATA, PSTRB);

	// Selector write; value is kept as written, low five bits select
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			selector_reg <= SELECTOR_RESET;
		end else if (wr_take && hit_sel) begin
			selector_reg <= sel_merged[7:0];
		end
	end

	// Record writes: direct index reaches word 0, window reaches all four
	generate
		for (genvar a = 0; a < AREA_COUNT; a++) begin : g_cfg
			wire we_direct = wr_take && hit_area &&
			                 (direct_idx == 5'(a));
			wire we_detail = wr_take && hit_detail &&
			                 (detail_idx == 5'(a));
			wire [1:0]  wsel = we_detail ? detail_wd : 2'h0;
			wire [31:0] wval = strobe_merge(rec_word(cfg_reg[a], wsel),
			                                PWDATA, PSTRB);

			// Middle and width reset to zero with the record; start and end reset to beam 1
			always_ff @(posedge SYS_CLK or posedge RESET) begin
				if (RESET) begin
					cfg_reg[a] <= AREA_CFG_RESET;
				end else if (we_direct || we_detail) begin
					cfg_reg[a] <= rec_put(cfg_reg[a], wsel, wval);
				end
			end

			// Beam numbers are taken as logical ones as written by the host
			bae_area_eval u_area (
				.clk          (SYS_CLK),
				.rst          (RESET),
				.cfg          (cfg_reg[a]),
				.refs         (BEAM_REFS),
				.beam_valid   (BEAM_VALID),
				.beam_num     (BEAM_NUM),
				.beam_blocked (BEAM_BLOCKED),
				.scan_end     (SCAN_END),
				.result       (results[a])
			);
		end
	endgenerate

	// Result snapshot; keeps status outputs on their own flops
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			status_reg <= 32'h0000_0000;
		end else begin
			status_reg <= results;
		end
	end

	// Port drive; every output comes straight from a flip-flop,
	// so pin timing does not depend on the decode depth
	assign PRDATA         = prdata_reg;
	assign PREADY         = pready_reg;
	assign PSLVERR        = pslverr_reg;
	assign AREA_STATUS_LO = status_reg[15:0];
	assign AREA_STATUS_HI = status_reg[31:16];

endmodule

// ===== dv/bae_monitor.sv
// Checker of bus answers and status timing at the top ports
`timescale 1ns/10ps
module bae_monitor
	import bae_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SCAN_END,
	input wire logic [15:0] AREA_STATUS_LO,
	input wire logic [15:0] AREA_STATUS_HI
);
	// Setup phase and word index of the request
	wire       setup = PSEL && !PENABLE;
	wire [9:0] idx   = PADDR[11:2];
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	ready_after_setup_a : assert property (setup |=> PREADY)
		else $error("ready not one cycle after setup");
	ready_one_cycle_a : assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	data_idle_zero_a : assert property (!PREADY |-> PRDATA == 0)
		else $error("read data outside answer");
	err_with_ready_a : assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	status_write_err_a : assert property
		(setup && PWRITE && idx == IDX_STATUS_LO |=> PSLVERR)
		else $error("status write not refused");
	lo_status_hold_a : assert property
		($changed(AREA_STATUS_LO) |-> $past(SCAN_END, 2))
		else $error("low status moved without scan end");
	hi_status_hold_a : assert property
		($changed(AREA_STATUS_HI) |-> $past(SCAN_END, 2))
		else $error("high status moved without scan end");
	sel_read_ok_a : assert property
		(setup && !PWRITE && idx == IDX_SELECTOR
		|=> !PSLVERR && PRDATA[31:8] == 0)
		else $error("selector read wrong");
	unmapped_err_a : assert property
		(setup && idx == 10'h3ff |=> PSLVERR && PRDATA == 0)
		else $error("unmapped access not refused");
endmodule

bind bae_top bae_monitor u_mon (.SYS_CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PRDATA, .PREADY, .PSLVERR, .SCAN_END, .AREA_STATUS_LO,
	.AREA_STATUS_HI);

// ===== dv/bae_scan_src.sv
// Beam scan source standing in for the curtain measurement logic
`timescale 1ns/10ps
module bae_scan_src
	import bae_pkg::*;
(
	input  wire logic    clk,
	output logic         beam_valid,
	output logic [15:0]  beam_num,
	output logic         beam_blocked,
	output logic         scan_end,
	output bae_refs_type refs
);
	initial begin
		beam_valid = 1'b0;
		beam_num = 16'h0000;
		beam_blocked = 1'b0;
		scan_end = 1'b0;
		refs = '0;
	end
	// One beam a cycle; refs held through the scan; idle lines toggle
	task automatic scan(input int n, input logic [31:0] dark,
		input bae_refs_type r);
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			refs <= r;
			beam_valid <= 1'b1;
			beam_num <= 16'(i);
			beam_blocked <= dark[i-1];
			scan_end <= (i == n);
		end
		@(posedge clk);
		beam_valid <= 1'b0;
		scan_end <= 1'b0;
		beam_num <= ~beam_num;
		beam_blocked <= ~beam_blocked;
	endtask
endmodule

// ===== dv/beam_area_block_evaluation_tb_top.sv
// Self-checking bench for the area evaluation top
`timescale 1ns/10ps
module beam_area_block_evaluation_tb_top
	import bae_pkg::*;
;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic [31:0]  v;
	logic         pready;
	logic         pslverr;
	logic         bv;
	logic         bb;
	logic         se;
	logic [15:0]  bn;
	bae_refs_type refs;
	bae_refs_type r;
	logic [32:0]  exp_q[$];
	logic [31:0]  stat_q[$];
	logic [15:0]  st_lo;
	logic [15:0]  st_hi;
	logic [3:0]   pstrb = 4'hf;
	logic [3:0]   strb = 4'hf;
	logic         se_d1 = 1'b0;
	logic         se_d2 = 1'b0;
	int           error_cnt = 0;
	int           check_count = 0;
	int           seed = 33209;
	always #5 clk = ~clk;
	bae_top u_dut (.SYS_CLK(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .BEAM_VALID(bv), .BEAM_NUM(bn),
		.BEAM_BLOCKED(bb), .SCAN_END(se), .BEAM_REFS(refs),
		.AREA_STATUS_LO(st_lo), .AREA_STATUS_HI(st_hi));
	bae_scan_src u_src (.clk(clk), .beam_valid(bv), .beam_num(bn),
		.beam_blocked(bb), .scan_end(se), .refs(refs));
	// Watcher: each answered transfer takes the oldest note
	always @(posedge clk)
		if (psel && penable && pready === 1'b1)
			check_resp({pslverr, prdata}, exp_q.pop_front());
	// Status pins settle one edge after the scan end is sampled
	always @(posedge clk) begin
		se_d1 <= se;
		se_d2 <= se_d1;
		if (se_d2 === 1'b1)
			check_stat({st_hi, st_lo}, stat_q.pop_front());
	end
	task automatic check_stat(input logic [31:0] seen, e);
		check_count++;
		if (seen !== e) begin
			error_cnt++;
			$display("Error status pins expected %h seen %h", e, seen);
		end
	endtask
	task automatic check_resp(input logic [32:0] seen, e);
		check_count++;
		if (seen !== e) begin
			error_cnt++;
			$display("Error resp expected %h seen %h", e, seen);
		end
	endtask
	// Held until ready is sampled high, then released at that edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? strb : 4'h0;
		exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		// No limit here: only the watchdog ends a hung transfer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {1'b0, d});
	endtask
	// Area setup through the detail window
	task automatic cfg(input logic [7:0] s, input logic [15:0] st, en,
		on, off, input logic [7:0] ena, pol);
		wr(12'h18c, {24'h0, s});
		wr(12'h404, {on, off});
		wr(12'h408, {st, en});
		wr(12'h40c, {16'h0, ena, pol});
	endtask
	// Status shows one edge after the scan end edge
	task automatic ev(input logic [31:0] dark, input logic [15:0] lo, hi);
		stat_q.push_back({hi, lo});
		u_src.scan(10, dark, r);
		repeat (2) @(posedge clk);
		rd(12'h278, {16'h0, lo});
		rd(12'h27c, {16'h0, hi});
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog far beyond the expected run length
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	// Main sequence
	initial begin
		r = {5{16'd10}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(12'h18c, 32'h0);
		rd(12'h190, 32'h0);
		rd(12'h408, 32'h00010001);
		rd(12'h40c, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 32; i += 31) begin
			v = $random(seed);
			wr(12'h190 + 12'(4 * i), v);
			rd(12'h190 + 12'(4 * i), v);
		end
		wr(12'h18c, 32'h0000001f);
		rd(12'h400, v);
		strb = 4'h3;
		wr(12'h20c, 32'h0);
		strb = 4'hf;
		rd(12'h20c, {v[31:16], 16'h0000});
		v = $random(seed);
		wr(12'h18c, v);
		rd(12'h18c, {24'h0, v[7:0]});
		apb(1'b1, 12'h278, 32'h1, {1'b1, 32'h0});
		apb(1'b0, 12'hffc, 32'h0, {1'b1, 32'h0});
		$display("test regs done");
		cfg(0, 1, 10, 6, 3, 1, 0);
		ev(32'h00f, 16'h0001, 16'h0);
		ev(32'h03f, 16'h0001, 16'h0);
		ev(32'h07f, 16'h0000, 16'h0);
		cfg(0, 10, 1, 6, 3, 1, 1);
		ev(32'h07f, 16'h0001, 16'h0);
		cfg(0, 10, 1, 6, 3, 0, 1);
		ev(32'h07f, 16'h0000, 16'h0);
		cfg(31, 1, 10, 1, 0, 1, 1);
		ev(32'h001, 16'h0000, 16'h8000);
		$display("test eval done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(12'h190, 32'h0);
		rd(12'h408, 32'h00010001);
		rd(12'h27c, 32'h0);
		$display("test reset again done");
		for (int k = 0; k < 5; k++) begin
			r = {5{16'd10}};
			r[79 - 16 * k -: 16] = 16'd8;
			cfg(31, 16'hfffe - 16'(k), 10, 3, 2, 1, 1);
			ev(32'h3ff, 16'h0, 16'h8000);
			ev(32'h000, 16'h0, 16'h0000);
		end
		$display("test codes done");
		stop_test();
	end
endmodule
